// File: verilog/car_pkg.sv
/*
 * car_pkg: constants and types shared by the chained converter readout logic.
 * assumes a 200 MHz system clock and a host-driven serial clock.
 */
package car_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CAR_CLK_PS = 5000;
    // conversion time of the internal converter, in ns
    localparam int CAR_T_CONV_NS = 2000;
    localparam int CAR_CONV_CYCLES = (CAR_T_CONV_NS * 1000 + CAR_CLK_PS - 1) / CAR_CLK_PS;
    localparam int CAR_TIMER_W = 9;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int CAR_RES_W = 16;
    localparam int CAR_SYNC_W = 3;
    localparam logic [CAR_RES_W-1:0] CAR_RES_RST = 16'h0000;
    localparam logic [CAR_TIMER_W-1:0] CAR_TIMER_RST = 9'h000;
    localparam logic [CAR_SYNC_W-1:0] CAR_SYNC_RST = 3'h0;

    // index of each pin in the synchroniser bank
    localparam int CAR_PIN_STROBE = 0;
    localparam int CAR_PIN_CHAIN = 1;
    localparam int CAR_PIN_SCK = 2;
    localparam int CAR_PIN_TGL = 3;
    localparam int CAR_PIN_N = 4;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        CAR_IDLE = 5'b00001,
        CAR_CONV = 5'b00010,
        CAR_WAIT_UP = 5'b00100,
        CAR_READ = 5'b01000,
        CAR_CS_HOLD = 5'b10000
    } car_state_t;

    // serial pin output group
    typedef struct packed {
        logic data;
        logic oe;
    } car_pin_out_t;

    typedef struct packed {
        logic [CAR_SYNC_W-1:0] stage;
        logic level;
    } car_sync_st_t;

    typedef struct packed {
        logic bit_in;
        logic tgl;
    } car_link_st_t;

    typedef struct packed {
        car_state_t state;
        logic busy_en;
        logic busy_bit;
        logic head;
        logic strobe_d;
        logic tgl_d;
        logic [CAR_RES_W-1:0] sample;
        logic [CAR_RES_W-1:0] sh;
        logic [CAR_TIMER_W-1:0] timer;
        car_pin_out_t pin;
        logic power_down;
        logic conv_busy;
    } car_main_st_t;

endpackage : car_pkg

// File: verilog/car_sync.sv
/*
 * car_sync: three-stage synchroniser for one asynchronous level; the level
 * changes once the second and third stages agree.
 * assumes a glitch-free source held longer than two system clocks.
 */
`timescale 1ns/1ps
module car_sync
    import car_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level
);

    car_sync_st_t st;
    car_sync_st_t next_st;

    always_comb begin
        next_st = st;
        // stage[0] feeds only stage[1]
        next_st.stage = {st.stage[CAR_SYNC_W-2:0], pin_in};
        if (st.stage[1] == st.stage[2]) begin
            next_st.level = st.stage[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '{stage: CAR_SYNC_RST, level: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

endmodule : car_sync

// File: verilog/car_link.sv
/*
 * car_link: serial clock domain of the chained readout. captures the chain
 * input on every falling serial clock edge and toggles an event flag.
 * assumes the serial clock is stopped while rst is applied and released.
 */
`timescale 1ns/1ps
module car_link
    import car_pkg::*;
(
    input wire logic link_sck,
    input wire logic rst,
    input wire logic chain_data_in,
    output logic link_bit,
    output logic link_tgl
);

    car_link_st_t st;
    car_link_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.bit_in = chain_data_in; // [RQ8]
        next_st.tgl = ~st.tgl;
    end

    // clock may stand still, so reset cannot wait for an edge here
    always_ff @(negedge link_sck or posedge rst) begin
        if (rst) begin
            st <= '{bit_in: 1'b0, tgl: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign link_bit = st.bit_in;
    assign link_tgl = st.tgl;

endmodule : car_link

// File: verilog/car_readout.sv
/*
 * car_readout: conversion start, busy indication and chained serial readout
 * of one 16-bit converter, seen from inside the device.
 * assumes a host that drives the strobe and serial clock, a digital result on
 * analog_code at the strobe rising edge, and a level strap marking the chain head.
 */
//
// Summary of operation
// RQ1 - with chain input and strobe both low the serial output is driven low.
// RQ2 - strobe rise with chain input low and serial clock high starts a chained conversion with busy.
// RQ3 - the host keeps the strobe high through conversion and readback.
// RQ4 - the nearest device raises its output only after every converter in the chain is done.
// RQ5 - the host may start clocking out data on that rising output.
// RQ6 - after signalling completion the device returns to acquisition and powers down; the code powers down at conversion end, before the busy-mode output rise.
// RQ7 - the result leaves most significant bit first, one bit per later serial clock fall.
// RQ8 - the chain input is shifted in at each serial clock fall so upstream data passes through.
// RQ9 - output data stay valid across both serial clock edges.
// RQ10 - the host should sample on the falling serial clock edge when its hold time allows.
// RQ11 - the output returns low after edge 16 times N plus one or at a strobe rise.
// RQ12 - each chained device contributes its own result most significant bit first.
// RQ13 - strobe rise with chain input and serial clock low starts a chained conversion without busy.
// RQ14 - strobe rise with chain input high selects chip-select operation and floats the output.
// RQ15 - at conversion end the result is loaded into the shift register before readout.
`timescale 1ns/1ps
module car_readout
    import car_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_sck,
    input wire logic convert_strobe,
    input wire logic chain_data_in,
    input wire logic chain_head,
    input wire logic [CAR_RES_W-1:0] analog_code,
    output logic chain_data_out,
    output logic chain_data_out_oe,
    output logic power_down,
    output logic conv_busy
);

    // ----------------------------------------------------------------
    // link domain and synchronisers
    // ----------------------------------------------------------------
    logic link_bit;
    logic link_tgl;
    logic [CAR_PIN_N-1:0] pin_raw;
    logic [CAR_PIN_N-1:0] pin_lvl;

    car_link u_link (
        .link_sck(link_sck),
        .rst(rst),
        .chain_data_in(chain_data_in),
        .link_bit(link_bit),
        .link_tgl(link_tgl)
    );

    assign pin_raw[CAR_PIN_STROBE] = convert_strobe;
    assign pin_raw[CAR_PIN_CHAIN] = chain_data_in;
    assign pin_raw[CAR_PIN_SCK] = link_sck;
    assign pin_raw[CAR_PIN_TGL] = link_tgl;

    for (genvar i = 0; i < CAR_PIN_N; i++) begin : g_sync
        car_sync u_sync (
            .sys_clk(sys_clk),
            .rst(rst),
            .pin_in(pin_raw[i]),
            .level(pin_lvl[i])
        );
    end

    logic strobe_s;
    logic chain_s;
    logic sck_s;
    logic tgl_s;

    assign strobe_s = pin_lvl[CAR_PIN_STROBE];
    assign chain_s = pin_lvl[CAR_PIN_CHAIN];
    assign sck_s = pin_lvl[CAR_PIN_SCK];
    assign tgl_s = pin_lvl[CAR_PIN_TGL];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    car_main_st_t st;
    car_main_st_t next_st;
    logic strobe_rise;
    logic sck_fall;

    assign strobe_rise = strobe_s & ~st.strobe_d;
    // captured bit is held a whole serial period, far longer than the sync delay
    assign sck_fall = tgl_s ^ st.tgl_d;

    always_comb begin
        next_st = st;
        next_st.strobe_d = strobe_s;
        next_st.tgl_d = tgl_s;
        // strap caught by the clock, never by the reset itself
        next_st.head = chain_head;
        next_st.conv_busy = 1'b0;
        next_st.power_down = 1'b1;

        unique case (st.state)
            CAR_IDLE: begin
                if (!strobe_s && !chain_s) begin
                    next_st.pin = '{data: 1'b0, oe: 1'b1}; // [RQ1]
                end
            end

            CAR_CONV: begin
                next_st.conv_busy = 1'b1;
                next_st.power_down = 1'b0;
                if (!strobe_s && !chain_s) begin
                    next_st.pin = '{data: 1'b0, oe: 1'b1}; // [RQ1]
                end
                if (st.timer == CAR_TIMER_RST) begin
                    next_st.conv_busy = 1'b0;
                    next_st.power_down = 1'b1; // [RQ6]
                    next_st.sh = st.sample; // [RQ15]
                    if (st.busy_en) begin
                        next_st.state = CAR_WAIT_UP;
                    end else begin
                        // without busy the msb goes straight onto the pin
                        next_st.pin = '{data: st.sample[CAR_RES_W-1], oe: 1'b1}; // [RQ7]
                        next_st.state = CAR_READ;
                    end
                end else begin
                    next_st.timer = st.timer - 1'b1;
                end
            end

            CAR_WAIT_UP: begin
                // upstream device raises its output only when it is done
                if (st.head || chain_s) begin
                    next_st.pin = '{data: 1'b1, oe: 1'b1}; // [RQ4]
                    next_st.busy_bit = 1'b1;
                    next_st.state = CAR_READ;
                end
            end

            CAR_READ: begin
                if (!strobe_s && !chain_s) begin
                    next_st.pin = '{data: 1'b0, oe: 1'b1}; // [RQ1]
                    next_st.state = CAR_IDLE;
                end else if (sck_fall) begin
                    if (st.busy_bit) begin
                        // first fall only retires the busy bit; upstream shows its
                        // busy bit at the same time, so nothing is taken in
                        next_st.busy_bit = 1'b0;
                        next_st.pin.data = st.sh[CAR_RES_W-1]; // [RQ7]
                    end else begin
                        // far end of the chain feeds zeros, so the pin falls low
                        // after the last result bit has passed
                        next_st.sh = {st.sh[CAR_RES_W-2:0], link_bit}; // [RQ8] [RQ11]
                        next_st.pin.data = st.sh[CAR_RES_W-2]; // [RQ7] [RQ12]
                    end
                end
            end

            CAR_CS_HOLD: begin
                next_st.pin = '{data: 1'b0, oe: 1'b0}; // [RQ14]
                // the conversion still runs here; only the readout stays floated
                if (st.timer != CAR_TIMER_RST) begin
                    next_st.conv_busy = 1'b1; // [RQ14]
                    next_st.power_down = 1'b0;
                    next_st.timer = st.timer - 1'b1;
                end
                if (!strobe_s && !chain_s) begin
                    next_st.pin = '{data: 1'b0, oe: 1'b1}; // [RQ1]
                    next_st.state = CAR_IDLE;
                end
            end
        endcase

        // a new start ends any readout at once
        if (strobe_rise) begin
            next_st.sample = analog_code;
            next_st.busy_bit = 1'b0;
            next_st.timer = CAR_TIMER_W'(CAR_CONV_CYCLES - 1);
            if (chain_s) begin
                next_st.state = CAR_CS_HOLD;
                next_st.pin = '{data: 1'b0, oe: 1'b0}; // [RQ14]
            end else begin
                next_st.state = CAR_CONV;
                next_st.busy_en = sck_s; // [RQ2] [RQ13]
                next_st.pin = '{data: 1'b0, oe: 1'b1}; // [RQ11]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '{
                state: CAR_IDLE,
                busy_en: 1'b0,
                busy_bit: 1'b0,
                head: 1'b0,
                strobe_d: 1'b0,
                tgl_d: 1'b0,
                sample: CAR_RES_RST,
                sh: CAR_RES_RST,
                timer: CAR_TIMER_RST,
                pin: '{data: 1'b0, oe: 1'b0},
                power_down: 1'b1,
                conv_busy: 1'b0
            };
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // data changes a few system clocks after each serial fall and then holds
    // for the rest of the period, so both serial edges see it
    assign chain_data_out = st.pin.data; // [RQ9]
    assign chain_data_out_oe = st.pin.oe;
    assign power_down = st.power_down;
    assign conv_busy = st.conv_busy;

endmodule : car_readout

// File: tb/car_readout_asserts.sv
/* concurrent checks on the ports of car_readout.
   assumes a bind from the bench top and a 200 MHz sys_clk. */
`timescale 1ns/1ps
module car_readout_asserts
    import car_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_sck,
    input wire logic convert_strobe,
    input wire logic chain_data_in,
    input wire logic chain_data_out,
    input wire logic chain_data_out_oe,
    input wire logic power_down,
    input wire logic conv_busy
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic [CAR_TIMER_W:0] busy_cnt;

    // ----
    // conversion length counter, cleared whenever not converting
    // ----
    always_ff @(posedge sys_clk) begin
        if (rst || !conv_busy) begin
            busy_cnt <= '0;
        end else begin
            busy_cnt <= busy_cnt + 1'b1;
        end
    end

    AST_IDLE_LOW: assert property (
        (!convert_strobe && !chain_data_in) [*8] |-> !chain_data_out && chain_data_out_oe)
        else $error("idle output not driven low");
    AST_START_CHAIN: assert property (
        $rose(convert_strobe) && !chain_data_in |-> ##[2:8] (conv_busy && !chain_data_out
        && chain_data_out_oe)) else $error("chained start not seen");
    AST_CS_FLOAT: assert property (
        $rose(convert_strobe) && chain_data_in |-> ##[2:8] (conv_busy && !chain_data_out_oe))
        else $error("chip-select start did not float output");
    AST_BUSY_QUIET: assert property (
        conv_busy && chain_data_out_oe |-> !chain_data_out)
        else $error("output high during conversion");
    AST_CONV_LEN: assert property (
        $fell(conv_busy) && convert_strobe |-> busy_cnt inside
        {[CAR_CONV_CYCLES-1:CAR_CONV_CYCLES+1]}) else $error("conversion length wrong");
    AST_PD_DONE: assert property (
        $fell(conv_busy) |-> power_down) else $error("no power down after conversion");
    AST_PD_EXCL: assert property (
        conv_busy |-> !power_down) else $error("powered down while converting");
    AST_FALL_STABLE: assert property (
        $fell(link_sck) && convert_strobe && !conv_busy |=> $stable(chain_data_out) [*3])
        else $error("output moved right after serial fall");

    cover property ($fell(conv_busy));
    cover property ($rose(chain_data_out));
    cover property ($rose(convert_strobe) && chain_data_in);
endmodule : car_readout_asserts

// File: tb/car_host_model.sv
/* host and upstream converter seen from the device pins.
   assumes the bench calls its tasks just after a sys_clk edge. */
`timescale 1ns/1ps
module car_host_model
    import car_pkg::*;
(
    input wire logic sys_clk,
    input wire logic chain_data_out,
    output logic convert_strobe,
    output logic chain_data_in,
    output logic link_sck
);
    logic got[$];
    logic busy_q;
    logic [CAR_RES_W-1:0] up_q;

    initial begin
        convert_strobe = 1'b0;
        chain_data_in = 1'b0;
        link_sck = 1'b0;
    end

    // upstream stream: busy flag first in busy mode, then msb first, zeros after
    function automatic logic up_bit(input int j);
        if (busy_q) begin
            return (j == 0) ? 1'b1 : (j <= 16) ? up_q[16-j] : 1'b0;
        end
        return (j < 16) ? up_q[15-j] : 1'b0;
    endfunction : up_bit

    task automatic start(input logic busy, input logic chain_hi);
        @(posedge sys_clk);
        convert_strobe <= 1'b0;
        link_sck <= busy;
        chain_data_in <= chain_hi;
        repeat (8) @(posedge sys_clk);
        convert_strobe <= 1'b1;
    endtask : start

    task automatic stop();
        @(posedge sys_clk);
        convert_strobe <= 1'b0;
        chain_data_in <= 1'b0;
    endtask : stop

    // odd offset keeps serial edges off the sys_clk grid
    task automatic frame(input logic busy, input logic [CAR_RES_W-1:0] up, input int n);
        busy_q = busy;
        up_q = up;
        got.delete();
        @(posedge sys_clk);
        #1.3;
        chain_data_in = up_bit(0);
        link_sck = 1'b1;
        if (busy) begin
            wait (chain_data_out === 1'b1);
        end
        repeat (4) @(posedge sys_clk);
        #1.3;
        for (int j = 1; j <= n; j++) begin
            got.push_back(chain_data_out);
            link_sck = 1'b0;
            #24;
            link_sck = 1'b1;
            chain_data_in = up_bit(j);
            #24;
        end
    endtask : frame
endmodule : car_host_model

// File: tb/car_readout_tb_top.sv
/* bench top for car_readout: host model, corner and random frames.
   assumes package, design, checker and host model compile first. */
`timescale 1ns/1ps
module car_readout_tb_top
    import car_pkg::*;
();
    logic sys_clk;
    logic rst;
    logic link_sck;
    logic convert_strobe;
    logic chain_data_in;
    logic chain_head;
    logic [CAR_RES_W-1:0] analog_code;
    logic chain_data_out;
    logic chain_data_out_oe;
    logic power_down;
    logic conv_busy;
    int bad_count;
    int total_checks;
    int tests;

    car_readout u_dut (.sys_clk, .rst, .link_sck, .convert_strobe, .chain_data_in, .chain_head,
        .analog_code, .chain_data_out, .chain_data_out_oe, .power_down, .conv_busy);
    car_host_model u_host (.sys_clk, .chain_data_out, .convert_strobe, .chain_data_in, .link_sck);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // sample k is the level left by serial fall k-1
    function automatic logic exp_bit(input logic busy, input logic [CAR_RES_W-1:0] own,
            input logic [CAR_RES_W-1:0] up, input int k);
        int e;
        e = busy ? k - 2 : k - 1;
        return (e < 0) ? 1'b1 : (e < 16) ? own[15-e] : (e < 32) ? up[31-e] : 1'b0;
    endfunction : exp_bit

    task automatic idle_check();
        u_host.stop();
        repeat (10) @(posedge sys_clk);
        chk(chain_data_out, 1'b0);
        chk(chain_data_out_oe, 1'b1);
        tests++;
        $display("test %0d done, %0d checks", tests, total_checks);
    endtask : idle_check

    // n below 17 leaves the readout open so the next start aborts it
    task automatic run_test(input logic busy, input logic head, input logic [CAR_RES_W-1:0] own,
            input logic [CAR_RES_W-1:0] up, input int n);
        chain_head <= head;
        analog_code <= own;
        u_host.start(busy, 1'b0);
        repeat (20) @(posedge sys_clk);
        chk(conv_busy, 1'b1);
        chk(power_down, 1'b0);
        chk(chain_data_out, 1'b0);
        repeat (400) @(posedge sys_clk);
        chk(power_down, 1'b1);
        if (busy) begin
            chk(chain_data_out, head);
        end
        u_host.frame(busy, up, n);
        for (int k = 1; k <= n; k++) begin
            chk(u_host.got[k-1], exp_bit(busy, own, up, k));
        end
        if (n > 16) begin
            idle_check();
        end else begin
            tests++;
            $display("test %0d done, %0d checks", tests, total_checks);
        end
    endtask : run_test

    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // nine frames and one chip-select test of up to about 800 cycles each, with ample margin
    initial begin
        repeat (30000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        chain_head = 1'b0;
        analog_code = '0;
        bad_count = 0;
        total_checks = 0;
        tests = 0;
        void'($urandom(32'hc771e16b));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        run_test(1'b1, 1'b1, 16'hffff, 16'h0000, 34);
        run_test(1'b1, 1'b0, 16'h8001, 16'h7ffe, 34);
        run_test(1'b0, 1'b0, 16'h0000, 16'hffff, 34);
        run_test(1'b1, 1'b1, 16'ha5a5, 16'h0000, 6);
        run_test(1'b0, 1'b0, 16'h5a5a, 16'hc3c3, 34);
        u_host.start(1'b0, 1'b1);
        repeat (20) @(posedge sys_clk);
        chk(chain_data_out_oe, 1'b0);
        chk(conv_busy, 1'b1);
        repeat (400) @(posedge sys_clk);
        chk(chain_data_out_oe, 1'b0);
        chk(power_down, 1'b1);
        idle_check();
        for (int i = 0; i < 4; i++) begin
            run_test(1'($urandom), 1'($urandom), 16'($urandom), 16'($urandom), 34);
        end
        end_of_test();
    end
endmodule : car_readout_tb_top

bind car_readout car_readout_asserts u_asserts (.sys_clk, .rst, .link_sck, .convert_strobe,
    .chain_data_in, .chain_data_out, .chain_data_out_oe, .power_down, .conv_busy);
